// ### verilog/gsw_pkg.sv
// constants and carrier types for the gateway status word block
// assumes one clock domain; the input data area is read by the fieldbus side
package gsw_pkg;

  // ****************************************************************
  // register map and field layout
  // ****************************************************************
  localparam logic [9:0] GSW_STATUS_OFS = 10'h000;
  localparam logic [9:0] GSW_CONTROL_OFS = 10'h200;
  localparam int GSW_SEND_BIT = 15;
  localparam int GSW_CONFIRM_BIT = 14;
  localparam int GSW_VALID_BIT = 13;
  localparam int GSW_CTL_CONFIRM_BIT = 15;
  localparam int GSW_CTL_SEND_BIT = 14;
  localparam logic [15:0] GSW_STATUS_RESET = 16'h0000;

  // ****************************************************************
  // status codes
  // ****************************************************************
  localparam logic [4:0] GSW_CODE_0 = 5'h00;
  localparam logic [4:0] GSW_CODE_1 = 5'h01;
  localparam logic [4:0] GSW_CODE_2 = 5'h02;
  localparam logic [4:0] GSW_CODE_3 = 5'h03;
  localparam logic [4:0] GSW_CODE_4 = 5'h04;
  localparam logic [4:0] GSW_CODE_NONE = 5'h1f;
  localparam logic [7:0] GSW_NO_DATA = 8'h00;

  // event indexes, in priority order (lowest index wins)
  localparam int GSW_EV_COUNT = 6;
  localparam int GSW_EV_FAULT = 0;   // other error
  localparam int GSW_EV_MULTI = 1;   // master: several missing
  localparam int GSW_EV_SINGLE = 2;  // master: one missing
  localparam int GSW_EV_CNT2 = 3;    // generic: timeout count
  localparam int GSW_EV_CNT0 = 4;    // retrans / invalid count
  localparam int GSW_EV_WARN = 5;    // overrun / frame error

  typedef struct packed {
    logic [4:0] code;
    logic [7:0] data;
  } gsw_report_type;

  typedef struct packed {
    logic send;
    logic confirm;
    logic valid;
    gsw_report_type report;
  } gsw_status_type;

  // subnetwork-side event inputs
  typedef struct packed {
    logic retrans_update;     // master
    logic [7:0] retrans_count;
    logic node_missing;       // master, level
    logic [7:0] missing_count;
    logic [7:0] missing_addr;
    logic overrun;            // both modes
    logic [7:0] overrun_addr;
    logic other_error;        // level, both modes
    logic [7:0] other_addr;
    logic invalid_update;     // generic
    logic [7:0] invalid_count;
    logic frame_error;        // generic
    logic timeout_update;     // generic
    logic [7:0] timeout_count;
  } gsw_events_type;

  typedef enum {
    GSW_OFFLINE,
    GSW_WAIT_CTL,
    GSW_WAIT_DONE,
    GSW_EXCHANGE
  } gsw_part_type;

endpackage

// ### verilog/gsw_status_word.sv
// status word producer of the gateway input data area
// assumes event inputs are synchronous one-cycle pulses or levels
`timescale 1ns/100ps
module gsw_status_word (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic enable_i,
  input wire logic generic_mode_i,
  input wire logic online_i,
  input wire logic all_done_i,
  input wire gsw_pkg::gsw_events_type events_i,
  input wire logic [15:0] control_word_i,
  input wire logic [9:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic [15:0] status_word_o,
  output logic report_blocked_o
);
  import gsw_pkg::*;

  // ****************************************************************
  // handshake and report selection
  // ****************************************************************
  logic send_reg;
  logic confirm_reg;
  logic valid_reg;
  gsw_report_type report_reg;
  gsw_report_type pend_reg;
  logic pend_valid_reg;
  logic err_active_reg;
  gsw_part_type part_reg;
  logic [GSW_EV_COUNT-1:0] ev;
  logic [GSW_EV_COUNT-1:0] ev_raw;
  logic [GSW_EV_COUNT-1:0] ev_seen_reg;
  gsw_report_type ev_rep;
  logic ev_any;
  logic ctl_confirm;
  logic ctl_send;
  logic can_post;
  logic cause_gone;
  logic ctl_valid;

  assign ctl_confirm = control_word_i[GSW_CTL_CONFIRM_BIT];
  assign ctl_send = control_word_i[GSW_CTL_SEND_BIT];
  assign ctl_valid = control_word_i[GSW_VALID_BIT];
  // previous report acknowledged when confirm mirrors send
  assign can_post = (ctl_confirm == send_reg);

  always_comb begin
    ev_raw = '0;
    ev_raw[GSW_EV_FAULT] = events_i.other_error;
    ev_raw[GSW_EV_MULTI] = !generic_mode_i && events_i.node_missing &&
                           (events_i.missing_count > 8'h01);
    ev_raw[GSW_EV_SINGLE] = !generic_mode_i && events_i.node_missing &&
                            (events_i.missing_count <= 8'h01);
    ev_raw[GSW_EV_CNT2] = generic_mode_i && events_i.timeout_update;
    ev_raw[GSW_EV_CNT0] = generic_mode_i ? events_i.invalid_update :
                          events_i.retrans_update;
    ev_raw[GSW_EV_WARN] = events_i.overrun ||
                          (generic_mode_i && events_i.frame_error);
  end

  // level conditions report once on their rise, not every cycle they stand
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ev_seen_reg <= '0;
    end else begin
      ev_seen_reg <= ev_raw;
    end
  end

  always_comb begin
    ev = ev_raw;
    if (ev_seen_reg[GSW_EV_FAULT]) begin
      ev[GSW_EV_FAULT] = 1'b0;
    end
    if (ev_seen_reg[GSW_EV_MULTI]) begin
      ev[GSW_EV_MULTI] = 1'b0;
    end
    if (ev_seen_reg[GSW_EV_SINGLE]) begin
      ev[GSW_EV_SINGLE] = 1'b0;
    end
  end

  assign cause_gone = !events_i.other_error && !events_i.node_missing;

  always_comb begin
    ev_any = |ev;
    ev_rep = '{code: GSW_CODE_NONE, data: GSW_NO_DATA};
    if (ev[GSW_EV_FAULT]) begin
      ev_rep.code = GSW_CODE_4;
      ev_rep.data = generic_mode_i ? GSW_NO_DATA : events_i.other_addr;
    end else if (ev[GSW_EV_MULTI]) begin
      ev_rep = '{code: GSW_CODE_2, data: events_i.missing_count};
    end else if (ev[GSW_EV_SINGLE]) begin
      ev_rep = '{code: GSW_CODE_1, data: events_i.missing_addr};
    end else if (ev[GSW_EV_CNT2]) begin
      ev_rep = '{code: GSW_CODE_2, data: events_i.timeout_count};
    end else if (ev[GSW_EV_CNT0]) begin
      ev_rep.code = GSW_CODE_0;
      ev_rep.data = generic_mode_i ? events_i.invalid_count :
                    events_i.retrans_count;
    end else if (ev[GSW_EV_WARN]) begin
      if (generic_mode_i) begin
        // overrun and frame error share no data in this mode
        ev_rep.code = events_i.overrun ? GSW_CODE_3 : GSW_CODE_1;
        ev_rep.data = GSW_NO_DATA;
      end else begin
        ev_rep = '{code: GSW_CODE_3, data: events_i.overrun_addr};
      end
    end
  end

  // ****************************************************************
  // pending report, held until the partner has confirmed the last one
  // ****************************************************************
  // a newer event replaces an older pending one; only the latest matters
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_valid_reg <= 1'b0;
      pend_reg <= '{code: GSW_CODE_NONE, data: GSW_NO_DATA};
      err_active_reg <= 1'b0;
    end else begin
      if (ev_any) begin
        pend_valid_reg <= 1'b1;
        pend_reg <= ev_rep;
        if (ev[GSW_EV_FAULT] || ev[GSW_EV_MULTI] || ev[GSW_EV_SINGLE] ||
            ev[GSW_EV_CNT2] || (generic_mode_i && ev[GSW_EV_CNT0])) begin
          err_active_reg <= 1'b1;
        end
      end else if (err_active_reg && cause_gone && !pend_valid_reg) begin
        // queued only once the error itself went out, never over it
        pend_valid_reg <= 1'b1;
        pend_reg <= '{code: GSW_CODE_NONE, data: GSW_NO_DATA};
        err_active_reg <= 1'b0;
      end else if (pend_valid_reg && can_post) begin
        pend_valid_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // posted report and send toggle
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      report_reg <= '{code: GSW_CODE_NONE, data: GSW_NO_DATA};
      send_reg <= 1'b0;
    end else if (pend_valid_reg && can_post && !ev_any) begin
      report_reg <= pend_reg;
      send_reg <= !send_reg;
    end
  end

  // confirm mirrors the partner's send flag once seen
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      confirm_reg <= 1'b0;
    end else begin
      confirm_reg <= ctl_send;
    end
  end

  // ****************************************************************
  // data-valid and fieldbus participation
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      part_reg <= GSW_OFFLINE;
    end else begin
      case (part_reg)
        GSW_OFFLINE: if (online_i) part_reg <= GSW_WAIT_CTL;
        GSW_WAIT_CTL: begin
          if (!online_i) part_reg <= GSW_OFFLINE;
          else if (ctl_valid) part_reg <= GSW_WAIT_DONE;
        end
        GSW_WAIT_DONE: begin
          if (!online_i) part_reg <= GSW_OFFLINE;
          else if (all_done_i) part_reg <= GSW_EXCHANGE;
        end
        GSW_EXCHANGE: if (!online_i) part_reg <= GSW_OFFLINE;
        default: part_reg <= GSW_OFFLINE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_reg <= 1'b0;
    end else if (generic_mode_i) begin
      valid_reg <= 1'b0;
    end else if (part_reg == GSW_OFFLINE && online_i) begin
      // apart from generic mode, only the participation sequence may clear the flag
      valid_reg <= 1'b0;
    end else if (part_reg == GSW_WAIT_DONE && all_done_i) begin
      valid_reg <= 1'b1;
    end else begin
      valid_reg <= valid_reg;
    end
  end

  // ****************************************************************
  // input data area view
  // ****************************************************************
  gsw_status_type word;
  assign word = '{send: send_reg, confirm: confirm_reg, valid: valid_reg,
                  report: report_reg};

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_word_o <= GSW_STATUS_RESET;
      rd_data_o <= GSW_NO_DATA;
      report_blocked_o <= 1'b0;
    end else begin
      status_word_o <= enable_i ? word : GSW_STATUS_RESET;
      report_blocked_o <= pend_valid_reg && !can_post;
      // big-endian: high byte at the lower address
      if (enable_i && rd_addr_i == GSW_STATUS_OFS) begin
        rd_data_o <= word[15:8];
      end else if (enable_i &&
                   rd_addr_i == GSW_STATUS_OFS + 10'h001) begin
        rd_data_o <= word[7:0];
      end else begin
        rd_data_o <= GSW_NO_DATA;
      end
    end
  end

endmodule

// ### dv/gsw_status_word_monitor.sv
// port checker for the gateway status word block
// assumes it is bound onto every gsw_status_word instance
`timescale 1ns/100ps
module gsw_status_word_monitor (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic enable_i,
  input wire logic generic_mode_i,
  input wire logic online_i,
  input wire logic all_done_i,
  input wire gsw_pkg::gsw_events_type events_i,
  input wire logic [15:0] control_word_i,
  input wire logic [9:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [15:0] status_word_o,
  input wire logic report_blocked_o
);
  import gsw_pkg::*;
  // ****************************************************************
  // history: outputs lag inputs, so checks wait for steady levels
  // ****************************************************************
  logic [2:0] en_reg;
  logic [7:0] on_reg;
  logic en_ok;
  assign en_ok = enable_i && (en_reg == 3'b111);
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_reg <= 3'b000;
      on_reg <= 8'h00;
    end else begin
      en_reg <= {en_reg[1:0], enable_i};
      on_reg <= {on_reg[6:0], online_i};
    end
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  a_off_word_zero: assert property (
    !enable_i && !$past(enable_i) |-> status_word_o == 16'h0000)
    else $error("status word not zero while disabled");
  a_generic_no_valid: assert property (
    generic_mode_i && $past(generic_mode_i, 2) |-> !status_word_o[13])
    else $error("data valid set in generic mode");
  a_valid_sticky: assert property (
    en_ok && !generic_mode_i && on_reg == 8'hff && $past(status_word_o[13])
    |-> status_word_o[13]) else $error("data valid dropped while online");
  a_read_high_byte: assert property (
    en_ok && rd_addr_i == 10'h000 |=> !$stable(status_word_o) ||
    rd_data_o == status_word_o[15:8]) else $error("byte 0 not high byte");
  a_read_other_zero: assert property (
    en_ok && rd_addr_i > 10'h001 |=> rd_data_o == 8'h00)
    else $error("read outside status word not zero");
  a_code_legal: assert property (
    en_ok |-> status_word_o[12:8] inside {[5'h00:5'h04], 5'h1f})
    else $error("undefined status code");
  a_send_waits_confirm: assert property (
    en_ok && $changed(status_word_o[15]) |-> $past(status_word_o[15]) ==
    $past(control_word_i[15]) || $past(status_word_o[15]) ==
    $past(control_word_i[15], 2)) else $error("report posted unconfirmed");
  a_report_with_send: assert property (
    en_ok && $changed(status_word_o[12:0]) |-> $changed(status_word_o[15]))
    else $error("report changed without send toggle");
  c_valid_set: cover property ($rose(status_word_o[13]));
  c_blocked: cover property ($rose(report_blocked_o));
  c_code_change: cover property (en_ok && $changed(status_word_o[12:8]));
endmodule
bind gsw_status_word gsw_status_word_monitor gsw_status_word_monitor_i (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .enable_i(enable_i),
  .generic_mode_i(generic_mode_i), .online_i(online_i),
  .all_done_i(all_done_i), .events_i(events_i),
  .control_word_i(control_word_i), .rd_addr_i(rd_addr_i),
  .rd_data_o(rd_data_o), .status_word_o(status_word_o),
  .report_blocked_o(report_blocked_o));

// ### dv/gsw_ctl_model.sv
// control-system model: echoes the send flag, drives data valid
// assumes it reads the status word every clock as input data
`timescale 1ns/100ps
module gsw_ctl_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic online_i,
  input wire logic slow_i,
  input wire logic [15:0] status_i,
  output logic [15:0] control_o
);
  // ****************************************************************
  // slow mode lags the echo so that new reports pile up behind it
  // ****************************************************************
  logic [3:0] wait_reg;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      control_o <= 16'h0000;
      wait_reg <= 4'h0;
    end else begin
      control_o[13] <= online_i && (control_o[13] || !status_i[13]);
      if (control_o[15] == status_i[15]) begin
        wait_reg <= 4'h0;
      end else if (!slow_i || wait_reg == 4'hf) begin
        control_o[15] <= status_i[15];
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// ### dv/gsw_status_word_tb.sv
// self-checking bench for the gateway status word block
// assumes the control-system model answers the handshake
`timescale 1ns/100ps
module gsw_status_word_tb;
  import gsw_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic enable_i = 1'b0;
  logic generic_mode_i = 1'b0;
  logic online_i = 1'b0;
  logic all_done_i = 1'b0;
  logic slow_i = 1'b0;
  logic send_exp = 1'b0;
  logic [9:0] rd_addr_i = 10'h000;
  gsw_events_type events_i = '0;
  logic [15:0] control_word_i;
  logic [7:0] rd_data_o;
  logic [15:0] status_word_o;
  logic report_blocked_o;
  int fail_count = 0;
  int check_count = 0;
  always #5 clock_i = ~clock_i;
  gsw_status_word gsw_status_word_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .enable_i(enable_i), .generic_mode_i(generic_mode_i),
    .online_i(online_i), .all_done_i(all_done_i), .events_i(events_i),
    .control_word_i(control_word_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .status_word_o(status_word_o),
    .report_blocked_o(report_blocked_o));
  gsw_ctl_model gsw_ctl_model_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .online_i(online_i), .slow_i(slow_i), .status_i(status_word_o),
    .control_o(control_word_i));
  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic gsw_events_type mk(input int k, input logic [7:0] v);
    gsw_events_type e;
    e = '0;
    case (k)
      0: {e.retrans_update, e.retrans_count} = {1'b1, v};
      1: {e.node_missing, e.missing_count, e.missing_addr} = {9'h101, v};
      2: {e.node_missing, e.missing_count} = {1'b1, v};
      3: {e.overrun, e.overrun_addr} = {1'b1, v};
      4: {e.other_error, e.other_addr} = {1'b1, v};
      5: {e.invalid_update, e.invalid_count} = {1'b1, v};
      6: e.frame_error = 1'b1;
      7: {e.timeout_update, e.timeout_count} = {1'b1, v};
      default: e = '0;
    endcase
    return e;
  endfunction
  // levels 1, 2 and 4 stay up; kind 8 drops every event
  task automatic post(input int k, input logic [7:0] v, input logic [12:0] e);
    send_exp = ~send_exp;
    @(posedge clock_i);
    events_i <= mk(k, v);
    @(posedge clock_i);
    events_i <= (k inside {1, 2, 4}) ? mk(k, v) : '0;
    for (int n = 0; n < 80 && status_word_o[15] !== send_exp; n++)
      @(negedge clock_i);
    check("send flag", {15'h0000, send_exp}, {15'h0000, status_word_o[15]});
    check("code and data", {3'b000, e}, {3'b000, status_word_o[12:0]});
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clock_i);
    rd_addr_i <= a;
    @(posedge clock_i);
    @(negedge clock_i);
    check("read byte", {8'h00, e}, {8'h00, rd_data_o});
  endtask
  task automatic wait_valid(input logic e);
    for (int n = 0; n < 40 && status_word_o[13] !== e; n++)
      @(negedge clock_i);
    check("data valid", {15'h0000, e}, {15'h0000, status_word_o[13]});
  endtask
  task automatic t_enable();
    rd(10'h000, 8'h00);
    check("disabled word", 16'h0000, status_word_o);
    @(posedge clock_i);
    enable_i <= 1'b1;
    repeat (4) @(negedge clock_i);
    check("idle word", 16'h1f00, status_word_o);
    $display("test enable done");
  endtask
  task automatic t_master();
    post(0, 8'h05, {5'h00, 8'h05});
    rd(10'h001, 8'h05);
    rd(10'h000, {send_exp, 7'h00});
    rd(10'h002, 8'h00);
    post(1, 8'h21, {5'h01, 8'h21});
    post(8, 8'h00, {5'h1f, 8'h00});
    post(2, 8'h03, {5'h02, 8'h03});
    post(8, 8'h00, {5'h1f, 8'h00});
    post(3, 8'h44, {5'h03, 8'h44});
    post(4, 8'h55, {5'h04, 8'h55});
    post(8, 8'h00, {5'h1f, 8'h00});
    $display("test master codes done");
  endtask
  task automatic t_valid();
    online_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    all_done_i <= 1'b1;
    wait_valid(1'b1);
    @(posedge clock_i);
    all_done_i <= 1'b0;
    post(0, 8'h06, {5'h00, 8'h06});
    check("valid kept", 16'h0001, {15'h0000, status_word_o[13]});
    @(posedge clock_i);
    online_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    online_i <= 1'b1;
    wait_valid(1'b0);
    $display("test data valid done");
  endtask
  task automatic t_generic();
    @(posedge clock_i);
    generic_mode_i <= 1'b1;
    slow_i <= 1'b1;
    post(5, 8'h07, {5'h00, 8'h07});
    post(6, 8'h00, {5'h01, 8'h00});
    post(7, 8'h09, {5'h02, 8'h09});
    post(3, 8'h44, {5'h03, 8'h00});
    post(4, 8'h55, {5'h04, 8'h00});
    post(8, 8'h00, {5'h1f, 8'h00});
    check("generic valid", 16'h0000, {15'h0000, status_word_o[13]});
    $display("test generic codes done");
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    $display("CHECK FAILED watchdog expected end seen timeout");
    conclude();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_enable();
    t_master();
    t_valid();
    t_generic();
    conclude();
  end
endmodule
